// ### verilog/dio_pkg.sv
// constants, register map and carrier types of the digital I/O channel block
// assumes a 125 MHz system clock and a 32-bit classic Wishbone slave port
`default_nettype none

package dio_pkg;

  localparam int NUM_DI = 2;
  localparam int NUM_DO = 2;
  localparam int NUM_RLY = 2;
  localparam int NUM_OUT = NUM_DO + NUM_RLY;

  // timing
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 500;
  localparam int SEC_US = 1000000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int SEC_CYCLES = SEC_US * CLK_MHZ;

  // highest power-on count that software may set
  localparam logic [31:0] COUNT_INIT_MAX = 32'hFFFF654F;

  // byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DI_BASE = 8'h10;
  localparam logic [7:0] DI_STRIDE = 8'h10;
  localparam logic [7:0] A_DO_BASE = 8'h40;
  localparam logic [7:0] DO_STRIDE = 8'h20;
  localparam logic [7:0] A_RLY_BASE = 8'h80;
  localparam logic [7:0] RLY_STRIDE = 8'h10;
  localparam logic [7:0] R_CFG = 8'h00;
  localparam logic [7:0] R_INIT = 8'h04;
  localparam logic [7:0] R_COUNT = 8'h08;
  localparam logic [7:0] R_DI_STAT = 8'h0C;
  localparam logic [7:0] R_PCOUNT = 8'h04;
  localparam logic [7:0] R_WIDTH = 8'h08;
  localparam logic [7:0] R_DO_STAT = 8'h0C;
  localparam logic [7:0] R_DO_CMD = 8'h10;
  localparam logic [7:0] R_RLY_CMD = 8'h04;
  localparam logic [7:0] R_RLY_STAT = 8'h08;

  // field positions and reset values
  localparam int CTRL_START = 0;
  localparam int STAT_RUN = 1;
  localparam logic [31:0] CFG_RST = 32'h00000000;
  localparam logic [31:0] WIDTH_RST = 32'h00010001;
  localparam logic [31:0] PCOUNT_RST = 32'h00000000;
  localparam logic [15:0] WIDTH_MIN = 16'h0001;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10
  } edge_t;

  typedef enum logic [1:0] {
    SAFE_OFF = 2'b00,
    SAFE_ON = 2'b01,
    SAFE_HOLD = 2'b10
  } safe_t;

  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_HIGH = 2'b01,
    PG_LOW = 2'b10
  } pg_state_t;

  typedef struct packed {
    logic [15:0] filter;
    logic [10:0] rsvd;
    logic retain;
    logic pwr_run;
    edge_t edge_sel;
    logic counter_mode;
  } di_cfg_t;

  typedef struct packed {
    logic [15:0] delay;
    logic [11:0] rsvd;
    safe_t safe;
    logic pwr_on;
    logic pulse_mode;
  } do_cfg_t;

  typedef struct packed {
    logic [15:0] delay;
    logic [13:0] rsvd;
    logic safe_on;
    logic pwr_on;
  } rly_cfg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

`default_nettype wire

// ### verilog/di_channel.sv
// one input channel: debounce filter and 32-bit event counter
// assumes din synchronous to clk_sys and tick a one-cycle 500 us enable
`timescale 1ns/1ps
`default_nettype none

module di_channel (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic din,
  input wire dio_pkg::di_cfg_t cfg,
  input wire logic load,
  input wire logic [31:0] load_val,
  input wire logic run_set,
  input wire logic run_clr,
  output logic level,
  output logic running,
  output logic [31:0] count
);
  import dio_pkg::*;

  logic [15:0] fcnt;
  logic level_q;
  logic ev;

  ////////////////////////////////////////////////////////////////////////////
  // debounce: count ticks while raw differs from accepted level
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      level <= 1'b0;
      fcnt <= 16'h0000;
    end
    else if (cfg.filter == 16'h0000)
    begin
      level <= din;
      fcnt <= 16'h0000;
    end
    else if (din == level)
      fcnt <= 16'h0000;
    else if (tick)
    begin
      if (16'(fcnt + 16'h0001) == cfg.filter)
      begin
        level <= din;
        fcnt <= 16'h0000;
      end
      else
        fcnt <= 16'(fcnt + 16'h0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge select on the filtered level
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      level_q <= 1'b0;
    else
      level_q <= level;
  end

  always_comb
  begin
    case (cfg.edge_sel)
      EDGE_RISE: ev = level & ~level_q;
      EDGE_FALL: ev = ~level & level_q;
      EDGE_BOTH: ev = level ^ level_q;
      default: ev = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and its run state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      running <= 1'b0;
    else if (run_set)
      running <= 1'b1;
    else if (run_clr)
      running <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      count <= 32'h00000000;
    else if (load)
      count <= load_val;
    else if (cfg.counter_mode && running && ev)
      count <= 32'(count + 32'h00000001);
  end

endmodule // di_channel

`default_nettype wire

// ### verilog/dio_channel_block.sv
// digital input, output and relay channels behind a classic Wishbone slave
// assumes field inputs synchronous to clk_sys; power-up is the start command
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dio_channel_block #(
  parameter int unsigned TICK_CYCLES = dio_pkg::TICK_CYCLES,
  parameter int unsigned SEC_CYCLES = dio_pkg::SEC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire dio_pkg::wb_req_t wb_req,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [dio_pkg::NUM_DI-1:0] din,
  input wire logic safe_mode,
  input wire logic power_fail,
  input wire logic [dio_pkg::NUM_DI-1:0][31:0] nv_rdata,
  output logic [dio_pkg::NUM_DI-1:0] nv_we,
  output logic [dio_pkg::NUM_DI-1:0][31:0] nv_wdata,
  output logic [dio_pkg::NUM_DO-1:0] dout,
  output logic [dio_pkg::NUM_RLY-1:0] relay
);
  import dio_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] base,
                               input logic [7:0] off);
    return adr == 8'(base + off);
  endfunction

  logic [7:0] a;
  logic acc;
  logic wr;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [31:0] rdata;
  logic [31:0] tick_cnt;
  logic [31:0] sec_cnt;
  logic tick;
  logic sec_tick;
  logic started;
  logic start_p;
  logic pf_q;
  logic [15:0] dly_cfg [NUM_OUT];
  logic [NUM_OUT-1:0] dly_done;
  logic [NUM_OUT-1:0] pwr_apply;
  logic [NUM_DO-1:0] next_dout;
  logic [NUM_RLY-1:0] next_relay;
  logic [31:0] di_cfg_r [NUM_DI];
  logic [NUM_DI-1:0] di_retain;
  logic [31:0] di_init_r [NUM_DI];
  logic [31:0] di_cnt_r [NUM_DI];
  logic [31:0] di_stat_r [NUM_DI];
  logic [31:0] do_cfg_r [NUM_DO];
  logic [31:0] do_pcnt_r [NUM_DO];
  logic [31:0] do_width_r [NUM_DO];
  logic [31:0] do_stat_r [NUM_DO];
  logic [31:0] do_cmd_r [NUM_DO];
  logic [31:0] rly_cfg_r [NUM_RLY];
  logic [31:0] rly_cmd_r [NUM_RLY];
  logic [31:0] rly_stat_r [NUM_RLY];

  assign a = {wb_req.adr[7:2], 2'b00};
  assign acc = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  assign wr = acc & wb_req.we;
  assign wd = wb_req.dat;
  assign ws = wb_req.sel;

  ////////////////////////////////////////////////////////////////////////////
  // 500 us tick and 1 s tick
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || tick_cnt == 32'(TICK_CYCLES - 1))
      tick_cnt <= 32'h00000000;
    else
      tick_cnt <= 32'(tick_cnt + 32'h00000001);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || sec_cnt == 32'(SEC_CYCLES - 1))
      sec_cnt <= 32'h00000000;
    else
      sec_cnt <= 32'(sec_cnt + 32'h00000001);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      tick <= 1'b0;
      sec_tick <= 1'b0;
    end
    else
    begin
      tick <= tick_cnt == 32'(TICK_CYCLES - 1);
      sec_tick <= sec_cnt == 32'(SEC_CYCLES - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up start, accepted once per reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      started <= 1'b0;
      start_p <= 1'b0;
    end
    else
    begin
      start_p <= wr && a == A_CTRL && ws[0] && wd[CTRL_START] && !started && !start_p;
      if (start_p)
        started <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power loss: hand retained counts to nonvolatile store
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pf_q <= 1'b0;
      nv_we <= '0;
      nv_wdata <= '0;
    end
    else
    begin
      pf_q <= power_fail;
      for (int i = 0; i < NUM_DI; i++)
      begin
        nv_we[i] <= power_fail && !pf_q && di_retain[i];
        if (power_fail && !pf_q)
          nv_wdata[i] <= di_cnt_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input channels
  for (genvar i = 0; i < NUM_DI; i++)
  begin : g_di
    localparam logic [7:0] B = 8'(A_DI_BASE + DI_STRIDE * i);
    di_cfg_t cfg;
    logic [31:0] init;
    logic [31:0] m;
    logic w_cnt;
    logic w_stat;
    logic level;
    logic running;
    logic [31:0] count;

    assign w_cnt = wr && hit(a, B, R_COUNT);
    assign w_stat = wr && hit(a, B, R_DI_STAT) && ws[0];
    assign m = merge(init, wd, ws);

    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
      begin
        cfg <= di_cfg_t'(CFG_RST);
        init <= CFG_RST;
      end
      else
      begin
        if (wr && hit(a, B, R_CFG))
          cfg <= di_cfg_t'(merge(cfg, wd, ws));
        if (wr && hit(a, B, R_INIT))
          init <= (m > COUNT_INIT_MAX) ? COUNT_INIT_MAX : m;
      end
    end

    di_channel di_channel_inst (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .tick(tick),
      .din(din[i]),
      .cfg(cfg),
      .load(start_p || w_cnt),
      .load_val(w_cnt ? merge(count, wd, ws) : (cfg.retain ? nv_rdata[i] : init)),
      .run_set((start_p && cfg.pwr_run) || (w_stat && wd[STAT_RUN])),
      .run_clr(w_stat && !wd[STAT_RUN]),
      .level(level),
      .running(running),
      .count(count)
    );

    assign di_cfg_r[i] = cfg;
    assign di_retain[i] = cfg.retain;
    assign di_init_r[i] = init;
    assign di_cnt_r[i] = count;
    assign di_stat_r[i] = {30'h00000000, running, level};
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on delay in whole seconds, one per output and relay
  for (genvar k = 0; k < NUM_OUT; k++)
  begin : g_dly
    logic [15:0] left;
    logic done;
    logic apply;

    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
      begin
        left <= 16'h0000;
        done <= 1'b0;
        apply <= 1'b0;
      end
      else
      begin
        apply <= 1'b0;
        if (start_p)
        begin
          left <= dly_cfg[k];
          done <= dly_cfg[k] == 16'h0000;
          apply <= dly_cfg[k] == 16'h0000;
        end
        else if (sec_tick && left != 16'h0000)
        begin
          left <= 16'(left - 16'h0001);
          done <= left == 16'h0001;
          apply <= left == 16'h0001;
        end
      end
    end

    assign dly_done[k] = done;
    assign pwr_apply[k] = apply;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output channels: level or pulse
  for (genvar j = 0; j < NUM_DO; j++)
  begin : g_do
    localparam logic [7:0] B = 8'(A_DO_BASE + DO_STRIDE * j);
    do_cfg_t cfg;
    logic [31:0] pcnt;
    logic [31:0] width;
    logic [31:0] left;
    logic [15:0] phase;
    logic [15:0] on_w;
    logic [15:0] off_w;
    logic level;
    logic run;
    logic eff_run;
    logic w_cmd;
    pg_state_t st;

    assign w_cmd = wr && hit(a, B, R_DO_CMD) && ws[0];
    assign on_w = (width[15:0] < WIDTH_MIN) ? WIDTH_MIN : width[15:0];
    assign off_w = (width[31:16] < WIDTH_MIN) ? WIDTH_MIN : width[31:16];
    assign dly_cfg[j] = cfg.delay;

    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
      begin
        cfg <= do_cfg_t'(CFG_RST);
        pcnt <= PCOUNT_RST;
        width <= WIDTH_RST;
      end
      else
      begin
        if (wr && hit(a, B, R_CFG))
          cfg <= do_cfg_t'(merge(cfg, wd, ws));
        if (wr && hit(a, B, R_PCOUNT))
          pcnt <= merge(pcnt, wd, ws);
        if (wr && hit(a, B, R_WIDTH))
          width <= merge(width, wd, ws);
      end
    end

    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
        level <= 1'b0;
      else if (pwr_apply[j] && !cfg.pulse_mode)
        level <= cfg.pwr_on;
      else if (w_cmd && !cfg.pulse_mode)
        level <= wd[0];
    end

    always_comb
    begin
      case (cfg.safe)
        SAFE_ON: eff_run = safe_mode | run;
        SAFE_OFF: eff_run = ~safe_mode & run;
        default: eff_run = run;
      endcase
    end

    // burst sequencer, advances on the 500 us tick
    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
      begin
        st <= PG_IDLE;
        run <= 1'b0;
        left <= 32'h00000000;
        phase <= 16'h0000;
      end
      else
      begin
        if (!eff_run || !cfg.pulse_mode || !dly_done[j])
          st <= PG_IDLE;
        else if (tick)
        begin
          case (st)
            PG_IDLE:
            begin
              st <= PG_HIGH;
              phase <= on_w;
              if (left == 32'h00000000)
                left <= pcnt;
            end
            PG_HIGH:
            begin
              if (phase <= 16'h0001)
              begin
                st <= PG_LOW;
                phase <= off_w;
              end
              else
                phase <= 16'(phase - 16'h0001);
            end
            PG_LOW:
            begin
              if (phase > 16'h0001)
                phase <= 16'(phase - 16'h0001);
              else if (pcnt != 32'h00000000 && left <= 32'h00000001)
              begin
                st <= PG_IDLE;
                run <= 1'b0;
                left <= 32'h00000000;
              end
              else
              begin
                st <= PG_HIGH;
                phase <= on_w;
                if (pcnt != 32'h00000000)
                  left <= 32'(left - 32'h00000001);
              end
            end
            default: st <= PG_IDLE;
          endcase
        end
        // trigger after the sequencer so a new start wins over burst end
        if (pwr_apply[j] && cfg.pulse_mode)
        begin
          run <= cfg.pwr_on;
          left <= pcnt;
        end
        else if (w_cmd && cfg.pulse_mode)
        begin
          run <= wd[0];
          left <= pcnt;
        end
      end
    end

    always_comb
    begin
      if (cfg.pulse_mode)
        next_dout[j] = st == PG_HIGH;
      else if (safe_mode)
        next_dout[j] = cfg.safe == SAFE_ON;
      else
        next_dout[j] = dly_done[j] & level;
    end

    assign do_cfg_r[j] = cfg;
    assign do_pcnt_r[j] = pcnt;
    assign do_width_r[j] = width;
    assign do_stat_r[j] = {29'h00000000, dly_done[j], run, dout[j]};
    assign do_cmd_r[j] = {31'h00000000, level};
  end

  ////////////////////////////////////////////////////////////////////////////
  // relay channels
  for (genvar r = 0; r < NUM_RLY; r++)
  begin : g_rly
    localparam logic [7:0] B = 8'(A_RLY_BASE + RLY_STRIDE * r);
    rly_cfg_t cfg;
    logic state;

    assign dly_cfg[NUM_DO + r] = cfg.delay;

    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
        cfg <= rly_cfg_t'(CFG_RST);
      else if (wr && hit(a, B, R_CFG))
        cfg <= rly_cfg_t'(merge(cfg, wd, ws));
    end

    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
        state <= 1'b0;
      else if (pwr_apply[NUM_DO + r])
        state <= cfg.pwr_on;
      else if (wr && hit(a, B, R_RLY_CMD) && ws[0])
        state <= wd[0];
    end

    assign next_relay[r] = safe_mode ? cfg.safe_on : (dly_done[NUM_DO + r] & state);
    assign rly_cfg_r[r] = cfg;
    assign rly_cmd_r[r] = {31'h00000000, state};
    assign rly_stat_r[r] = {30'h00000000, dly_done[NUM_DO + r], relay[r]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dout <= '0;
      relay <= '0;
    end
    else
    begin
      dout <= next_dout;
      relay <= next_relay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and bus answer; unmapped reads give zero
  always_comb
  begin
    rdata = 32'h00000000;
    if (a == A_CTRL)
      rdata = {31'h00000000, started};
    for (int i = 0; i < NUM_DI; i++)
    begin
      if (hit(a, 8'(A_DI_BASE + DI_STRIDE * i), R_CFG))
        rdata = di_cfg_r[i];
      if (hit(a, 8'(A_DI_BASE + DI_STRIDE * i), R_INIT))
        rdata = di_init_r[i];
      if (hit(a, 8'(A_DI_BASE + DI_STRIDE * i), R_COUNT))
        rdata = di_cnt_r[i];
      if (hit(a, 8'(A_DI_BASE + DI_STRIDE * i), R_DI_STAT))
        rdata = di_stat_r[i];
    end
    for (int j = 0; j < NUM_DO; j++)
    begin
      if (hit(a, 8'(A_DO_BASE + DO_STRIDE * j), R_CFG))
        rdata = do_cfg_r[j];
      if (hit(a, 8'(A_DO_BASE + DO_STRIDE * j), R_PCOUNT))
        rdata = do_pcnt_r[j];
      if (hit(a, 8'(A_DO_BASE + DO_STRIDE * j), R_WIDTH))
        rdata = do_width_r[j];
      if (hit(a, 8'(A_DO_BASE + DO_STRIDE * j), R_DO_STAT))
        rdata = do_stat_r[j];
      if (hit(a, 8'(A_DO_BASE + DO_STRIDE * j), R_DO_CMD))
        rdata = do_cmd_r[j];
    end
    for (int r = 0; r < NUM_RLY; r++)
    begin
      if (hit(a, 8'(A_RLY_BASE + RLY_STRIDE * r), R_CFG))
        rdata = rly_cfg_r[r];
      if (hit(a, 8'(A_RLY_BASE + RLY_STRIDE * r), R_RLY_CMD))
        rdata = rly_cmd_r[r];
      if (hit(a, 8'(A_RLY_BASE + RLY_STRIDE * r), R_RLY_STAT))
        rdata = rly_stat_r[r];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= acc;
      if (acc && !wb_req.we)
        wb_dat_o <= rdata;
    end
  end

endmodule // dio_channel_block

`default_nettype wire

// ### dv/dio_block_sva.sv
// bus and output checks on the digital I/O channel block ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module dio_block_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire dio_pkg::wb_req_t wb_req,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic power_fail,
  input wire logic [dio_pkg::NUM_DI-1:0] nv_we,
  input wire logic [dio_pkg::NUM_DO-1:0] dout,
  input wire logic [dio_pkg::NUM_RLY-1:0] relay
);
  import dio_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  //////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_req.cyc && wb_req.stb))
    else $error("ack without request");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  unmapped_zero_a: assert property (wb_ack_o && $past(!wb_req.we && (wb_req.adr[7:4] == 4'h3
    || wb_req.adr >= 8'hA0)) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  nv_pulse_a: assert property (|nv_we |=> nv_we == '0)
    else $error("store strobe longer than one cycle");
  nv_cause_a: assert property (|nv_we |-> $past(power_fail) && !$past(power_fail, 2))
    else $error("store strobe without power loss edge");
  outputs_off_a: assert property ($fell(sys_rst) |-> dout == '0 && relay == '0 ##1 dout == '0 && relay == '0)
    else $error("outputs on before start");
endmodule // dio_block_sva

bind dio_channel_block dio_block_sva dio_block_sva_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_req(wb_req),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .power_fail(power_fail), .nv_we(nv_we), .dout(dout), .relay(relay));

`default_nettype wire

// ### dv/field_switch.sv
// field switch model: contact follows target after some bounce cycles
// assumes target driven by the bench on clk_sys
`timescale 1ns/1ps
`default_nettype none

module field_switch #(
  parameter int BOUNCE = 0
) (
  input wire logic clk_sys,
  input wire logic target,
  output logic contact
);
  int left = 0;
  logic last = 1'b0;
  initial contact = 1'b0;
  // contact chatters while left runs down
  always @(posedge clk_sys)
  begin
    last <= target;
    if (target !== last)
      left <= BOUNCE;
    else if (left > 0)
      left <= left - 1;
    contact <= (left > 0) ? ~contact : target;
  end
endmodule // field_switch

`default_nettype wire

// ### dv/dio_channel_block_test.sv
// self-checking bench for the digital I/O channel block
// assumes short tick and second parameters, one clean switch (sw0) and one bouncing switch (sw1)
`timescale 1ns/1ps
`default_nettype none

module dio_channel_block_test;
  import dio_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  wb_req_t req = '0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic sw0;
  logic sw1;
  logic [1:0] press = 2'b00;
  logic safe_mode = 1'b0;
  logic power_fail = 1'b0;
  logic [NUM_DI-1:0][31:0] nv_rdata = {32'h00000055, 32'h00001234};
  logic [NUM_DI-1:0] nv_we;
  logic [NUM_DI-1:0][31:0] nv_wdata;
  logic [NUM_DO-1:0] dout;
  logic [NUM_RLY-1:0] relay;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checked = 0;

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  dio_channel_block #(.TICK_CYCLES(10), .SEC_CYCLES(50)) dio_channel_block_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wb_req(req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .din({sw1, sw0}),
    .safe_mode(safe_mode), .power_fail(power_fail), .nv_rdata(nv_rdata), .nv_we(nv_we),
    .nv_wdata(nv_wdata), .dout(dout), .relay(relay));
  field_switch #(.BOUNCE(0)) sw0_inst (.clk_sys(clk_sys), .target(press[0]), .contact(sw0));
  field_switch #(.BOUNCE(6)) sw1_inst (.clk_sys(clk_sys), .target(press[1]), .contact(sw1));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge clk_sys);
    end
    rd = wb_dat_o;
    req <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic s_setup();
    rdc(8'h68, WIDTH_RST);
    rdc(8'h30, 32'h0);
    bus(1'b1, 8'h10, 32'h00000019);
    bus(1'b1, 8'h14, 32'h00000007);
    bus(1'b1, 8'h20, 32'h0003000D);
    bus(1'b1, 8'h24, 32'hFFFFFFFF);
    rdc(8'h24, COUNT_INIT_MAX);
    bus(1'b1, 8'h40, 32'h00000002);
    bus(1'b1, 8'h60, 32'h0000000B);
    bus(1'b1, 8'h64, 32'h00000002);
    bus(1'b1, 8'h68, 32'h00010002);
    bus(1'b1, 8'h80, 32'h00000001);
    bus(1'b1, 8'h90, 32'h00010001);
    bus(1'b1, 8'h00, 32'h00000001);
    repeat (4) @(posedge clk_sys);
    chk(32'(dout[0]), 32'h1);
    chk(32'(relay[0]), 32'h1);
    chk(32'(relay[1]), 32'h0);
    rdc(8'h18, 32'h00001234);
    rdc(8'h28, COUNT_INIT_MAX);
    rdc(8'h1C, 32'h00000002);
  endtask

  task automatic s_count();
    press[0] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(8'h18, 32'h00001235);
    press[0] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdc(8'h18, 32'h00001235);
    bus(1'b1, 8'h18, 32'hFFFFFFFF);
    press[0] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(8'h18, 32'h00000000);
    press[0] <= 1'b0;
    press[1] <= 1'b1;
    repeat (15) @(posedge clk_sys);
    rdc(8'h28, COUNT_INIT_MAX);
    repeat (60) @(posedge clk_sys);
    rdc(8'h28, 32'hFFFF6550);
    press[1] <= 1'b0;
    repeat (80) @(posedge clk_sys);
    rdc(8'h28, 32'hFFFF6551);
    bus(1'b1, 8'h10, 32'h00000018);
    press[0] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(8'h1C, 32'h00000003);
    rdc(8'h18, 32'h00000000);
    bus(1'b1, 8'h10, 32'h0000001B);
    press[0] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdc(8'h18, 32'h00000001);
  endtask

  // burst of two, then continuous
  task automatic s_pulse();
    int highs;
    int rises;
    logic last;
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, 8'h64, (k == 0) ? 32'h2 : 32'h0);
      highs = 0;
      rises = 0;
      last = dout[1];
      bus(1'b1, 8'h70, 32'h1);
      repeat (200)
      begin
        @(posedge clk_sys);
        rises += int'(dout[1] && !last);
        highs += int'(dout[1]);
        last = dout[1];
      end
      if (k == 0)
      begin
        chk(32'(highs), 32'h28);
        chk(32'(rises), 32'h2);
        chk(32'(dout[1]), 32'h0);
      end
      else
        chk(32'(rises >= 6), 32'h1);
    end
    bus(1'b1, 8'h70, 32'h0);
    chk(32'(relay[1]), 32'h1);
  endtask

  // pulse channel set to safe ON while stopped
  task automatic s_safe();
    int highs;
    bus(1'b1, 8'h60, 32'h00000007);
    safe_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(32'(dout[0]), 32'h0);
    chk(32'(relay[0]), 32'h0);
    highs = 0;
    repeat (40)
    begin
      @(posedge clk_sys);
      highs += int'(dout[1]);
    end
    chk(32'(highs > 0), 32'h1);
    safe_mode <= 1'b0;
  endtask

  task automatic s_power();
    bus(1'b1, 8'h18, 32'h0000ABCD);
    power_fail <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(32'(nv_we), 32'h1);
    chk(nv_wdata[0], 32'h0000ABCD);
    power_fail <= 1'b0;
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    s_setup();
    s_count();
    s_pulse();
    s_safe();
    s_power();
    give_verdict();
  end
endmodule // dio_channel_block_test

`default_nettype wire
